// >>> include/dtv_pkg.sv
// constants for the converter test-value and sample-format register slice
// assumes an APB slave with 32-bit data, one register per aligned word
`default_nettype none
package dtv_pkg;
    // register indices; the byte address is four times the index
    localparam logic [9:0] DTV_IDX_CLK_DETECT = 10'h08E;
    localparam logic [9:0] DTV_IDX_DIG_TEST   = 10'h0F7;
    localparam logic [9:0] DTV_IDX_I_LOW      = 10'h0F8;
    localparam logic [9:0] DTV_IDX_I_HIGH     = 10'h0F9;
    localparam logic [9:0] DTV_IDX_Q_LOW      = 10'h0FA;
    localparam logic [9:0] DTV_IDX_Q_HIGH     = 10'h0FB;
    localparam logic [9:0] DTV_IDX_FORMAT     = 10'h110;
    localparam logic [9:0] DTV_IDX_IRQ_STATUS = 10'h120;
    localparam logic [9:0] DTV_IDX_IRQ_MASK   = 10'h121;

    // field positions
    localparam int DTV_POS_DET_EN   = 0;
    localparam int DTV_POS_DIFF_FLAG = 1;
    localparam int DTV_POS_CLK_PD   = 0;
    localparam int DTV_POS_TEST_EN  = 1;
    localparam int DTV_POS_FORMAT   = 7;
    localparam int DTV_POS_EV_RISE  = 0;
    localparam int DTV_POS_EV_FALL  = 1;

    // values after reset
    localparam logic [7:0] DTV_RST_DIG_TEST = 8'h1C;
    localparam logic [7:0] DTV_RST_BYTE     = 8'h00;
    localparam logic [1:0] DTV_RST_IRQ      = 2'h0;
    localparam logic       DTV_RST_BIT      = 1'b0;

    // sample format select values
    localparam logic DTV_FMT_TWOS   = 1'b0;
    localparam logic DTV_FMT_OFFSET = 1'b1;

    // channel count and width
    localparam int DTV_NUM_CHAN = 2;
    localparam int DTV_SAMPLE_W = 16;
endpackage : dtv_pkg
`default_nettype wire

// >>> logic/dtv_sync3.sv
// three-stage synchroniser with agreement filter for one pin level
// assumes the input is asynchronous to pclk
`default_nettype none
module dtv_sync3 (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // level in and filtered level out
    input  wire logic async_in,
    output var  logic sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } dtv_sync_type;

    dtv_sync_type st_r;
    dtv_sync_type st_nxt;

    // stage one feeds stage two only; the filter looks at two and three
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.q = st_r.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.q;
endmodule : dtv_sync3
`default_nettype wire

// >>> logic/dtv_chan_out.sv
// one converter channel: format conversion or constant test value
// assumes samples arrive on pclk; output is always twos complement
`default_nettype none
module dtv_chan_out (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // control
    input  wire logic        clk_run,
    input  wire logic        test_en,
    input  wire logic        fmt_sel,
    // data
    input  wire logic [15:0] sample_in,
    input  wire logic [15:0] test_value,
    output var  logic [15:0] dac_data
);
    typedef struct packed {
        logic [15:0] data;
    } dtv_chan_type;

    dtv_chan_type st_r;
    dtv_chan_type st_nxt;

    // a stopped digital clock freezes the channel
    always_comb begin
        st_nxt = st_r;
        if (clk_run) begin
            if (test_en) begin
                st_nxt.data = test_value;
            end else if (fmt_sel == dtv_pkg::DTV_FMT_OFFSET) begin
                st_nxt.data = {~sample_in[15], sample_in[14:0]};
            end else begin
                st_nxt.data = sample_in;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dac_data = st_r.data;
endmodule : dtv_chan_out
`default_nettype wire

// >>> logic/dtv_regs.sv
// register slice for clock detect, constant test values and sample format
// assumes an APB master on pclk and an asynchronous clock-type pin
//
// Operation
// - status bit 1 reads differential clock flag
// - detector runs only while enable bit set
// - powerdown bit stops top digital clock
// - test mode drives I with stored word
// - test mode drives Q with stored word
// - format bit 0 selects twos complement
// - format bit 1 selects offset binary
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
module dtv_regs (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // clock detector pin and controls
    input  wire logic        clk_diff_pin,
    output var  logic        clock_detector_enable,
    output var  logic        digital_clock_powerdown,
    // sample inputs
    input  wire logic [15:0] i_sample,
    input  wire logic [15:0] q_sample,
    // converter channel outputs
    output var  logic [15:0] i_dac_data,
    output var  logic [15:0] q_dac_data,
    // interrupt
    output var  logic        irq
);
    typedef struct packed {
        logic        det_en;
        logic        diff_flag;
        logic [7:0]  dig_test;
        logic [7:0]  i_low;
        logic [7:0]  i_high;
        logic [7:0]  q_low;
        logic [7:0]  q_high;
        logic [7:0]  fmt;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [31:0] rdata;
        logic        err;
    } dtv_regs_type;

    dtv_regs_type st_r;
    dtv_regs_type st_nxt;

    logic [9:0]  idx;
    logic        aligned;
    logic        mapped;
    logic        setup;
    logic        access;
    logic        wr_en;
    logic [7:0]  wbyte;
    logic [31:0] rd_word;
    logic        diff_sync;
    logic        diff_new;
    logic [1:0]  ev;
    logic        test_en;
    logic        fmt_sel;
    logic        clk_run;

    // channel buses for the generate loop
    logic [15:0] chan_sample [dtv_pkg::DTV_NUM_CHAN];
    logic [15:0] chan_value  [dtv_pkg::DTV_NUM_CHAN];
    logic [15:0] chan_data   [dtv_pkg::DTV_NUM_CHAN];

    // pin level of the clock type, filtered against glitches
    dtv_sync3 u_diff_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (clk_diff_pin),
        .sync_out (diff_sync)
    );

    // address decode; unaligned addresses are treated as unmapped
    assign idx     = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign wbyte   = pwdata[7:0];

    always_comb begin
        mapped = 1'b0;
        if (aligned) begin
            case (idx)
                dtv_pkg::DTV_IDX_CLK_DETECT: mapped = 1'b1;
                dtv_pkg::DTV_IDX_DIG_TEST:   mapped = 1'b1;
                dtv_pkg::DTV_IDX_I_LOW:      mapped = 1'b1;
                dtv_pkg::DTV_IDX_I_HIGH:     mapped = 1'b1;
                dtv_pkg::DTV_IDX_Q_LOW:      mapped = 1'b1;
                dtv_pkg::DTV_IDX_Q_HIGH:     mapped = 1'b1;
                dtv_pkg::DTV_IDX_FORMAT:     mapped = 1'b1;
                dtv_pkg::DTV_IDX_IRQ_STATUS: mapped = 1'b1;
                dtv_pkg::DTV_IDX_IRQ_MASK:   mapped = 1'b1;
                default:                     mapped = 1'b0;
            endcase
        end
    end

    // only byte lane 0 carries data; other lanes are ignored
    assign wr_en = access & pwrite & mapped & pstrb[0];

    // read word assembled in the setup cycle, held for the access phase
    always_comb begin
        rd_word = 32'h0000_0000;
        case (idx)
            dtv_pkg::DTV_IDX_CLK_DETECT: begin
                rd_word[dtv_pkg::DTV_POS_DIFF_FLAG] = st_r.diff_flag;
                rd_word[dtv_pkg::DTV_POS_DET_EN]  = st_r.det_en;
            end
            dtv_pkg::DTV_IDX_DIG_TEST: begin
                rd_word[7:0] = st_r.dig_test;
            end
            dtv_pkg::DTV_IDX_I_LOW: begin
                rd_word[7:0] = st_r.i_low;
            end
            dtv_pkg::DTV_IDX_I_HIGH: begin
                rd_word[7:0] = st_r.i_high;
            end
            dtv_pkg::DTV_IDX_Q_LOW: begin
                rd_word[7:0] = st_r.q_low;
            end
            dtv_pkg::DTV_IDX_Q_HIGH: begin
                rd_word[7:0] = st_r.q_high;
            end
            dtv_pkg::DTV_IDX_FORMAT: begin
                rd_word[7:0] = st_r.fmt;
            end
            dtv_pkg::DTV_IDX_IRQ_STATUS: begin
                rd_word[1:0] = st_r.irq_status;
            end
            dtv_pkg::DTV_IDX_IRQ_MASK: begin
                rd_word[1:0] = st_r.irq_mask;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
        if (!aligned) begin
            rd_word = 32'h0000_0000;
        end
    end

    // detector samples the pin only while enabled, else it holds
    always_comb begin
        diff_new = st_r.diff_flag;
        if (st_r.det_en) begin
            diff_new = diff_sync;
        end
    end

    // flag edges become interrupt events
    always_comb begin
        ev = 2'h0;
        ev[dtv_pkg::DTV_POS_EV_RISE] = diff_new & ~st_r.diff_flag;
        ev[dtv_pkg::DTV_POS_EV_FALL] = ~diff_new & st_r.diff_flag;
    end

    // register file next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.diff_flag = diff_new;
        if (setup) begin
            st_nxt.rdata = mapped ? rd_word : 32'h0000_0000;
            st_nxt.err   = ~mapped;
        end
        if (wr_en) begin
            case (idx)
                dtv_pkg::DTV_IDX_CLK_DETECT: begin
                    st_nxt.det_en = wbyte[dtv_pkg::DTV_POS_DET_EN];
                end
                dtv_pkg::DTV_IDX_DIG_TEST: begin
                    st_nxt.dig_test = wbyte;
                end
                dtv_pkg::DTV_IDX_I_LOW: begin
                    st_nxt.i_low = wbyte;
                end
                dtv_pkg::DTV_IDX_I_HIGH: begin
                    st_nxt.i_high = wbyte;
                end
                dtv_pkg::DTV_IDX_Q_LOW: begin
                    st_nxt.q_low = wbyte;
                end
                dtv_pkg::DTV_IDX_Q_HIGH: begin
                    st_nxt.q_high = wbyte;
                end
                dtv_pkg::DTV_IDX_FORMAT: begin
                    st_nxt.fmt = wbyte;
                end
                dtv_pkg::DTV_IDX_IRQ_STATUS: begin
                    st_nxt.irq_status = st_r.irq_status & ~wbyte[1:0];
                end
                dtv_pkg::DTV_IDX_IRQ_MASK: begin
                    st_nxt.irq_mask = wbyte[1:0];
                end
                default: begin
                    st_nxt.err = st_r.err;
                end
            endcase
        end
        // set wins over a clear in the same cycle
        st_nxt.irq_status = st_nxt.irq_status | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.det_en     <= dtv_pkg::DTV_RST_BIT;
            st_r.diff_flag  <= dtv_pkg::DTV_RST_BIT;
            st_r.dig_test   <= dtv_pkg::DTV_RST_DIG_TEST;
            st_r.i_low      <= dtv_pkg::DTV_RST_BYTE;
            st_r.i_high     <= dtv_pkg::DTV_RST_BYTE;
            st_r.q_low      <= dtv_pkg::DTV_RST_BYTE;
            st_r.q_high     <= dtv_pkg::DTV_RST_BYTE;
            st_r.fmt        <= dtv_pkg::DTV_RST_BYTE;
            st_r.irq_status <= dtv_pkg::DTV_RST_IRQ;
            st_r.irq_mask   <= dtv_pkg::DTV_RST_IRQ;
            st_r.rdata      <= 32'h0000_0000;
            st_r.err        <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // control decode feeding the channels
    assign test_en = st_r.dig_test[dtv_pkg::DTV_POS_TEST_EN];
    assign clk_run = ~st_r.dig_test[dtv_pkg::DTV_POS_CLK_PD];
    assign fmt_sel = st_r.fmt[dtv_pkg::DTV_POS_FORMAT];

    assign chan_sample[0] = i_sample;
    assign chan_sample[1] = q_sample;
    assign chan_value[0]  = {st_r.i_high, st_r.i_low};
    assign chan_value[1]  = {st_r.q_high, st_r.q_low};

    // one output stage per converter channel
    for (genvar c = 0; c < dtv_pkg::DTV_NUM_CHAN; c++) begin : g_chan
        dtv_chan_out u_chan (
            .pclk       (pclk),
            .presetn    (presetn),
            .clk_run    (clk_run),
            .test_en    (test_en),
            .fmt_sel    (fmt_sel),
            .sample_in  (chan_sample[c]),
            .test_value (chan_value[c]),
            .dac_data   (chan_data[c])
        );
    end

    assign i_dac_data = chan_data[0];
    assign q_dac_data = chan_data[1];

    // bus answers: zero wait states, error only on unmapped addresses
    assign pready  = 1'b1;
    assign prdata  = st_r.rdata;
    assign pslverr = access & st_r.err;

    // control pins straight from their register bits
    assign clock_detector_enable   = st_r.det_en;
    assign digital_clock_powerdown = st_r.dig_test[dtv_pkg::DTV_POS_CLK_PD];

    // level interrupt while any unmasked status bit stands
    assign irq = |(st_r.irq_status & st_r.irq_mask);
endmodule : dtv_regs
`default_nettype wire

// >>> verif/dtv_regs_chk.sv
// assertion checker for the register slice, sees top ports only
// assumes the bind at the foot of this file places it in dtv_regs
`default_nettype none
module dtv_regs_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pin and controls
    input wire logic        clk_diff_pin,
    input wire logic        clock_detector_enable,
    input wire logic        digital_clock_powerdown,
    // samples and channel outputs
    input wire logic [15:0] i_sample,
    input wire logic [15:0] q_sample,
    input wire logic [15:0] i_dac_data,
    input wire logic [15:0] q_dac_data,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // decoded accesses; a write needs strobe 0, the two register writes also an aligned address
    logic acc, wq, wr_pd, wr_det;
    assign acc    = psel && penable;
    assign wq     = acc && pwrite && pstrb[0];
    assign wr_pd  = wq && paddr == {dtv_pkg::DTV_IDX_DIG_TEST, 2'h0};
    assign wr_det = wq && paddr == {dtv_pkg::DTV_IDX_CLK_DETECT, 2'h0};

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unaligned_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access not refused");
    a_err_read_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_pd_follows: assert property (wr_pd |=> digital_clock_powerdown == $past(pwdata[0]))
        else $error("powerdown bit not written");
    a_pd_cause: assert property ($changed(digital_clock_powerdown) |-> $past(wr_pd))
        else $error("powerdown moved without a write");
    a_det_follows: assert property (wr_det |=> clock_detector_enable == $past(pwdata[0]))
        else $error("detector enable not written");
    a_det_cause: assert property ($changed(clock_detector_enable) |-> $past(wr_det))
        else $error("detector enable moved without a write");
    a_pd_freeze: assert property (digital_clock_powerdown |=> $stable(i_dac_data))
        else $error("i output moved while clock stopped");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(wq))
        else $error("irq dropped without a write");

    // main scenarios reached
    c_test_mode: cover property (wr_pd && pwdata[1]);
    c_irq_rise: cover property ($rose(irq));
    c_refused: cover property (acc && pslverr);
endmodule : dtv_regs_chk

bind dtv_regs dtv_regs_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .clk_diff_pin, .clock_detector_enable,
    .digital_clock_powerdown, .i_sample, .q_sample, .i_dac_data, .q_dac_data, .irq);
`default_nettype wire

// >>> verif/tb_dtv_regs.sv
// self-checking bench for the register slice over apb
// assumes dtv_pkg, dtv_regs and the checker are compiled first
`default_nettype none
module tb_dtv_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pslverr, pready;
    logic        irq, pin, det_en, pd, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [15:0] i_smp, q_smp, i_dac, q_dac;
    int          num_errors, n_compared;

    dtv_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .clk_diff_pin(pin), .clock_detector_enable(det_en),
        .digital_clock_powerdown(pd), .i_sample(i_smp), .q_sample(q_smp),
        .i_dac_data(i_dac), .q_dac_data(q_dac), .irq);

    // 100 mhz clock
    always #5 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // one transfer; held until pready is seen high, no wait count assumed
    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d,
                        input logic s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h0, d};
        pstrb   <= s ? 4'hF : 4'hE;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        xfer({i, 2'h0}, 1'b1, d, 1'b1);
    endtask : wr

    task automatic rc(input string nm, input logic [9:0] i, input logic [7:0] e);
        xfer({i, 2'h0}, 1'b0, 8'h00, 1'b1);
        chk(nm, {24'h0, e}, rd);
    endtask : rc

    // channel outputs, sampled mid-cycle once settled
    task automatic cd(input logic [15:0] ei, input logic [15:0] eq);
        repeat (3) @(negedge pclk);
        chk("i_dac", {16'h0, ei}, {16'h0, i_dac});
        chk("q_dac", {16'h0, eq}, {16'h0, q_dac});
    endtask : cd

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog against a hung transfer
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        pclk    = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, pin} = 4'h0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
        i_smp   = 16'h1357;
        q_smp   = 16'hF00D;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rc("dig_test", dtv_pkg::DTV_IDX_DIG_TEST, 8'h1C);
        rc("format", dtv_pkg::DTV_IDX_FORMAT, 8'h00);
        rc("clk_det", dtv_pkg::DTV_IDX_CLK_DETECT, 8'h00);
        // four test bytes: reset zero, then written and read back
        for (int k = 0; k < 4; k++) begin
            rc("tv_rst", dtv_pkg::DTV_IDX_I_LOW + 10'(k), 8'h00);
            wr(dtv_pkg::DTV_IDX_I_LOW + 10'(k), 8'(32'hABCD1234 >> (8 * k)));
            rc("tv", dtv_pkg::DTV_IDX_I_LOW + 10'(k), 8'(32'hABCD1234 >> (8 * k)));
        end
        cd(16'h1357, 16'hF00D);
        wr(dtv_pkg::DTV_IDX_FORMAT, 8'h80);
        cd(16'h9357, 16'h700D);
        wr(dtv_pkg::DTV_IDX_DIG_TEST, 8'h1E);
        cd(16'h1234, 16'hABCD);
        wr(dtv_pkg::DTV_IDX_DIG_TEST, 8'h1F);
        wr(dtv_pkg::DTV_IDX_I_LOW, 8'h55);
        cd(16'h1234, 16'hABCD);
        chk("pd", 32'h1, {31'h0, pd});
        wr(dtv_pkg::DTV_IDX_DIG_TEST, 8'h1E);
        cd(16'h1255, 16'hABCD);
        wr(dtv_pkg::DTV_IDX_DIG_TEST, 8'h1C);
        cd(16'h9357, 16'h700D);
        // strobe off is ignored, bad addresses refused
        xfer({dtv_pkg::DTV_IDX_I_LOW, 2'h0}, 1'b1, 8'hEE, 1'b0);
        rc("i_low", dtv_pkg::DTV_IDX_I_LOW, 8'h55);
        xfer(12'h3DD, 1'b0, 8'h00, 1'b1);
        chk("err", 32'h1, {31'h0, err});
        chk("bad_rd", 32'h0, rd);
        xfer(12'hFFC, 1'b1, 8'hFF, 1'b1);
        chk("err", 32'h1, {31'h0, err});
        // detector off: flag must hold while the pin moves
        pin <= 1'b1;
        repeat (12) @(posedge pclk);
        rc("clk_det", dtv_pkg::DTV_IDX_CLK_DETECT, 8'h00);
        wr(dtv_pkg::DTV_IDX_IRQ_MASK, 8'h03);
        wr(dtv_pkg::DTV_IDX_CLK_DETECT, 8'h01);
        repeat (12) @(posedge pclk);
        chk("det_en", 32'h1, {31'h0, det_en});
        rc("clk_det", dtv_pkg::DTV_IDX_CLK_DETECT, 8'h03);
        rc("status", dtv_pkg::DTV_IDX_IRQ_STATUS, 8'h01);
        chk("irq", 32'h1, {31'h0, irq});
        wr(dtv_pkg::DTV_IDX_IRQ_STATUS, 8'h01);
        wr(dtv_pkg::DTV_IDX_IRQ_MASK, 8'h01);
        chk("irq", 32'h0, {31'h0, irq});
        pin <= 1'b0;
        repeat (12) @(posedge pclk);
        rc("clk_det", dtv_pkg::DTV_IDX_CLK_DETECT, 8'h01);
        rc("status", dtv_pkg::DTV_IDX_IRQ_STATUS, 8'h02);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(dtv_pkg::DTV_IDX_IRQ_MASK, 8'h03);
        @(negedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        wr(dtv_pkg::DTV_IDX_IRQ_STATUS, 8'h02);
        // a one written to the read-only flag bit must not stick
        wr(dtv_pkg::DTV_IDX_CLK_DETECT, 8'h02);
        @(negedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        chk("det_en", 32'h0, {31'h0, det_en});
        rc("clk_det_ro", dtv_pkg::DTV_IDX_CLK_DETECT, 8'h00);
        tally_and_finish();
    end
endmodule : tb_dtv_regs
`default_nettype wire
